// *** hdl/dsw_port.sv ***
// Serial write port of a 12-bit converter: frame capture and code register.
`timescale 1ns/1ps
// Summary of operation
// - The shift register is enabled only while frame-select is low.
// - Data is sampled into a 16-bit shifter on falling serial clock edges.
// - On the 16th falling edge with frame-select low the code is updated.
// - Frame-select rising before the 16th edge discards the partial word.
// - After reset the output code is zero until a complete frame arrives.
// - The converter register holds a 12-bit unsigned code for the output.
module dsw_port
   import dsw_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SCLK,
   input wire logic FRAME_SEL_N,
   input wire logic SDATA,
   output logic [CODE_BITS-1:0] ANALOG_OUTPUT,
   output logic ANALOG_VALID,
   output logic CODE_STROBE,
   output logic FRAME_ABORT
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // The code field must lie inside the frame, and the bit counter must
   // be able to reach the last bit of a frame.
   if (CODE_LSB + CODE_BITS > FRAME_BITS) begin : g_bad_code
      $error("Code field does not fit in the frame.");
   end
   if (FRAME_BITS > (1 << CNT_BITS)) begin : g_bad_count
      $error("Bit counter too narrow for the frame.");
   end
   if (FRAME_BITS - 1 != int'(LAST_BIT)) begin : g_bad_last
      $error("Last bit index does not match the frame length.");
   end

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   // Every pin passes two flip-flops before any logic reads it. Serial
   // clock and data share the same delay, so each data bit is taken at
   // the same relative moment as the clock edge that it belongs to.
   logic [PIN_COUNT-1:0] pin_in;
   logic [PIN_COUNT-1:0] pin_sync;
   logic sclk_fall, sel_fall, sel_low, din_bit;

   // Returns high when a synchronised level has just gone from one to zero.
   function automatic logic fell(input logic prev, input logic now);
      return prev && !now;
   endfunction

   assign pin_in[PIN_SCLK] = SCLK;
   assign pin_in[PIN_SEL] = FRAME_SEL_N;
   assign pin_in[PIN_DATA] = SDATA;

   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
      logic meta_q, meta_d;
      logic sync_q, sync_d;

      always_comb begin
         meta_d = pin_in[i];
         sync_d = meta_q;
      end

      // Reset to the idle levels, so that no false edge follows reset.
      always_ff @(posedge CORE_CLK) begin
         if (RST) begin
            meta_q <= PIN_IDLE[i];
            sync_q <= PIN_IDLE[i];
         end else if (CE) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
         end
      end

      assign pin_sync[i] = sync_q;
   end

   // ------------------------------------------------------------
   // Edge history
   // ------------------------------------------------------------
   // Only the clock and frame-select levels need a previous copy.
   logic sclk_prev_q, sclk_prev_d, sel_prev_q, sel_prev_d;

   always_comb begin
      sclk_prev_d = pin_sync[PIN_SCLK];
      sel_prev_d = pin_sync[PIN_SEL];
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sclk_prev_q <= PIN_IDLE[PIN_SCLK];
         sel_prev_q <= PIN_IDLE[PIN_SEL];
      end else if (CE) begin
         sclk_prev_q <= sclk_prev_d;
         sel_prev_q <= sel_prev_d;
      end
   end

   assign sclk_fall = fell(sclk_prev_q, pin_sync[PIN_SCLK]);
   assign sel_fall = fell(sel_prev_q, pin_sync[PIN_SEL]);
   assign sel_low = !pin_sync[PIN_SEL];
   assign din_bit = pin_sync[PIN_DATA];

   // ------------------------------------------------------------
   // Frame capture
   // ------------------------------------------------------------
   dsw_state_type state_q, state_d;
   logic [FRAME_BITS-1:0] shift_q, shift_d;
   logic [CNT_BITS-1:0] cnt_q, cnt_d;
   logic push, abort_d, abort_q;
   logic in_ready;
   dsw_word_type word;

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      push = 1'b0;
      abort_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (sel_fall) begin
               state_d = ST_SHIFT;
               cnt_d = CNT_RESET;
               shift_d = SHIFT_RESET;
            end
         end
         ST_SHIFT: begin
            if (!sel_low) begin
               state_d = ST_IDLE;
               abort_d = 1'b1;
            end else if (sclk_fall && in_ready) begin
               shift_d = {shift_q[FRAME_BITS-2:0], din_bit};
               cnt_d = cnt_q + 5'h0_001;
               if (cnt_q == LAST_BIT) begin
                  push = 1'b1;
                  state_d = ST_WAIT;
               end
            end
         end
         // Serial clock edges after a complete word are ignored here.
         ST_WAIT: begin
            if (!sel_low) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_q <= ST_IDLE;
         shift_q <= SHIFT_RESET;
         cnt_q <= CNT_RESET;
         abort_q <= 1'b0;
      end else if (CE) begin
         state_q <= state_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         abort_q <= abort_d;
      end
   end

   // The word completed this cycle is the shifter with the last bit added.
   assign word.code = shift_d[CODE_LSB +: CODE_BITS];

   // ------------------------------------------------------------
   // Buffer and converter register
   // ------------------------------------------------------------
   logic buf_valid;
   logic [CODE_BITS-1:0] buf_data;
   logic [CODE_BITS-1:0] code_q, code_d;
   logic valid_q, valid_d, strobe_q, strobe_d;

   // The converter register takes every word at once, so the buffer
   // never fills and no serial clock edge is ever refused.
   dsw_buf #(
      .WIDTH(CODE_BITS)
   ) u_buf (
      .clk(CORE_CLK),
      .rst(RST),
      .ce(CE),
      .in_valid(push),
      .in_ready(in_ready),
      .in_data(word.code),
      .out_valid(buf_valid),
      .out_ready(1'b1),
      .out_data(buf_data)
   );

   always_comb begin
      code_d = code_q;
      valid_d = valid_q;
      strobe_d = 1'b0;
      if (buf_valid) begin
         code_d = buf_data;
         valid_d = 1'b1;
         strobe_d = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         code_q <= CODE_RESET;
         valid_q <= 1'b0;
         strobe_q <= 1'b0;
      end else if (CE) begin
         code_q <= code_d;
         valid_q <= valid_d;
         strobe_q <= strobe_d;
      end
   end

   assign ANALOG_OUTPUT = code_q;
   assign ANALOG_VALID = valid_q;
   assign CODE_STROBE = strobe_q;
   assign FRAME_ABORT = abort_q;
endmodule

// *** hdl/dsw_pkg.sv ***
// Package with constants and types for the serial converter write port.
package dsw_pkg;
   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int CODE_LSB = 0;
   localparam int CNT_BITS = 5;
   localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h0_00F;
   localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h0_000;
   localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CORE_CLK_KHZ = 25000;
   localparam int SCLK_MAX_KHZ = 30000;
   localparam int BUF_DEPTH = 2;
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   localparam int PIN_COUNT = 3;
   localparam int PIN_SCLK = 0;
   localparam int PIN_SEL = 1;
   localparam int PIN_DATA = 2;
   localparam logic [PIN_COUNT-1:0] PIN_IDLE = 3'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_WAIT = 3'b100
   } dsw_state_type;

   typedef struct packed {
      logic [CODE_BITS-1:0] code;
   } dsw_word_type;
endpackage

// *** hdl/dsw_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module dsw_buf
   import dsw_pkg::*;
#(
   parameter int WIDTH = CODE_BITS
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be positive.");
   end

   logic [WIDTH-1:0] mem_q [BUF_DEPTH];
   logic [WIDTH-1:0] mem_d [BUF_DEPTH];
   logic [1:0] cnt_q, cnt_d;
   logic wr, rd;

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[0];
   assign wr = in_valid && in_ready;
   assign rd = out_valid && out_ready;

   always_comb begin
      mem_d = mem_q;
      cnt_d = cnt_q;
      if (rd) begin
         mem_d[0] = mem_q[1];
      end
      if (wr) begin
         if (rd) begin
            mem_d[~cnt_q[0]] = in_data;
         end else begin
            mem_d[cnt_q[0]] = in_data;
         end
      end
      cnt_d = cnt_q + {1'b0, wr} - {1'b0, rd};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 2'h0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end
endmodule

// *** test/dsw_port_asserts.sv ***
// Assertion checker for the serial write port.
`timescale 1ns/1ps
module dsw_port_chk
   import dsw_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SCLK,
   input wire logic FRAME_SEL_N,
   input wire logic SDATA,
   input wire logic [CODE_BITS-1:0] ANALOG_OUTPUT,
   input wire logic ANALOG_VALID,
   input wire logic CODE_STROBE,
   input wire logic FRAME_ABORT
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   a_code_holds: assert property (
      !CODE_STROBE |-> $stable(ANALOG_OUTPUT))
      else $error("code moved without strobe");
   a_strobe_one: assert property (
      CODE_STROBE |=> !CODE_STROBE)
      else $error("strobe too long");
   a_abort_keeps: assert property (
      FRAME_ABORT |-> (!CODE_STROBE) [*8])
      else $error("abort with update");
   a_zero_first: assert property (
      !ANALOG_VALID |-> ANALOG_OUTPUT == CODE_RESET)
      else $error("code before first frame");
   a_strobe_valid: assert property (
      CODE_STROBE |-> ANALOG_VALID)
      else $error("strobe without valid");
   a_valid_stays: assert property (
      ANALOG_VALID |=> ANALOG_VALID)
      else $error("valid dropped");
   a_idle_quiet: assert property (
      FRAME_SEL_N [*8] |-> !CODE_STROBE)
      else $error("update while deselected");
endmodule
bind dsw_port dsw_port_chk chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .CE(CE),
   .SCLK(SCLK), .FRAME_SEL_N(FRAME_SEL_N), .SDATA(SDATA),
   .ANALOG_OUTPUT(ANALOG_OUTPUT), .ANALOG_VALID(ANALOG_VALID),
   .CODE_STROBE(CODE_STROBE), .FRAME_ABORT(FRAME_ABORT));

// *** test/dsw_host.sv ***
// Behavioural host that writes frames over the three-wire link.
`timescale 1ns/1ps
module dsw_host;
   logic sclk = 1'b1;
   logic sel_n = 1'b1;
   logic sdata = 1'b0;
   // Sends the top n bits of w and then releases the frame.
   // Called on a core clock edge; every change lands on a later edge.
   task automatic send(input logic [15:0] w, input int n);
      sel_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sdata <= w[15-i];
         #160 sclk <= 1'b0;
         #160 sclk <= 1'b1;
      end
      #320 sel_n <= 1'b1;
      sdata <= ~sdata;
   endtask
endmodule

// *** test/dsw_port_test.sv ***
// Self-checking testbench for the serial write port.
`timescale 1ns/1ps
module dsw_port_test
   import dsw_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [CODE_BITS-1:0] out;
   logic valid, strobe, abort_p;
   int fails = 0;
   int checked = 0;
   int n_strobe = 0;
   int n_abort = 0;
   always #20 clk = ~clk;
   dsw_host host_u();
   dsw_port dut_u (.CORE_CLK(clk), .RST(rst), .CE(ce), .SCLK(host_u.sclk),
      .FRAME_SEL_N(host_u.sel_n), .SDATA(host_u.sdata), .ANALOG_OUTPUT(out),
      .ANALOG_VALID(valid), .CODE_STROBE(strobe), .FRAME_ABORT(abort_p));
   always @(posedge clk) begin
      if (strobe === 1'b1) n_strobe++;
      if (abort_p === 1'b1) n_abort++;
   end
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         fails++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic stop_test;
      $display("fails=%0d checked=%0d", fails, checked);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Sends one frame, then checks the pulse counts and the code.
   task automatic frame(input logic [15:0] w, input int n,
         input logic [CODE_BITS-1:0] exp);
      int s0;
      int a0;
      s0 = n_strobe;
      a0 = n_abort;
      host_u.send(w, n);
      repeat (8) @(posedge clk);
      chk(n_strobe == s0 + (n == 16), "strobe count");
      chk(n_abort == a0 + (n < 16), "abort count");
      chk(out === exp, "code");
   endtask
   task automatic t_reset;
      chk(out === CODE_RESET, "reset code");
      frame(16'h0FFF, 15, CODE_RESET);
      chk(valid === 1'b0, "valid early");
   endtask
   task automatic t_write;
      frame(16'hA5C3, 16, 12'h5C3);
      chk(valid === 1'b1, "valid");
   endtask
   task automatic t_abort;
      frame(16'h0FFF, 1, 12'h5C3);
      frame(16'h8001, 16, 12'h001);
   endtask
   task automatic t_back;
      frame(16'hFFFF, 16, 12'hFFF);
      frame(16'h1000, 16, 12'h000);
   endtask
   // A reset in mid-run brings the code back to zero until a full frame.
   task automatic t_rst2;
      frame(16'h0ABC, 16, 12'hABC);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(out === CODE_RESET, "code after reset");
      chk(valid === 1'b0, "valid after reset");
      frame(16'h0123, 15, CODE_RESET);
      chk(valid === 1'b0, "valid after cut frame");
      frame(16'h0123, 16, 12'h123);
      chk(valid === 1'b1, "valid after frame");
   endtask
   // A frame sent while the clock enable is low leaves no trace.
   task automatic t_freeze;
      int s0;
      int a0;
      s0 = n_strobe;
      a0 = n_abort;
      ce <= 1'b0;
      @(posedge clk);
      host_u.send(16'h0777, 16);
      repeat (8) @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      chk(n_strobe == s0, "strobe while frozen");
      chk(n_abort == a0, "abort while frozen");
      chk(out === 12'h123, "code while frozen");
      frame(16'h0456, 16, 12'h456);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset();
      t_write();
      t_abort();
      t_back();
      t_rst2();
      t_freeze();
      stop_test();
   end
   initial begin
      #200000;
      fails++;
      stop_test();
   end
endmodule
